// File: cfsd_alu.sv
// constants and the operand datapath for compare, decimal adjust and decrement
package cfsd_pkg;
  // ==========================================================
  // instruction encodings and field positions
  localparam logic [6:0] CMP_LT_PATTERN = 7'h30;
  localparam logic [5:0] DEC_PATTERN = 6'h01;
  localparam logic [15:0] DAW_WORD = 16'h0007;
  localparam int A_BIT = 8;
  localparam int D_BIT = 9;
  // ==========================================================
  // addressing and arithmetic constants
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;
  localparam logic [7:0] OV_EDGE = 8'h80;
  localparam logic [1:0] SKIP_ONE = 2'h1;
  localparam logic [1:0] SKIP_TWO = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10
  } cfsd_phase_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00, OP_CMP_LT = 2'b01, OP_DAW = 2'b11, OP_DEC = 2'b10
  } cfsd_op_t;
  // ==========================================================
  // decode of one fetched word
  function automatic cfsd_op_t decode(input logic [15:0] w);
    if (w[15:9] == CMP_LT_PATTERN) decode = OP_CMP_LT;
    else if (w[15:10] == DEC_PATTERN) decode = OP_DEC;
    else if (w == DAW_WORD) decode = OP_DAW;
    else decode = OP_NONE;
  endfunction
  // access bank splits the low half to bank 0 and the high half to bank f
  function automatic logic [11:0] form_addr(input logic [7:0] f,
      input logic a, input logic [3:0] bank);
    if (a) form_addr = {bank, f};
    else if (f < ACCESS_SPLIT) form_addr = {ACCESS_LOW_BANK, f};
    else form_addr = {ACCESS_HIGH_BANK, f};
  endfunction
endpackage

// ==========================================================
// combinational operand datapath
module cfsd_alu (
  // operation and operands
  input wire cfsd_pkg::cfsd_op_t op,
  input wire logic [7:0] f_byte,
  input wire logic [7:0] w_byte,
  input wire logic c_in,
  input wire logic dc_in,
  // results
  output logic [7:0] result,
  output logic c_out,
  output logic dc_out,
  output logic n_out,
  output logic ov_out,
  output logic z_out,
  output logic less
);
  logic lo_fix;
  logic hi_fix;
  logic [8:0] sum1;
  logic [8:0] sum2;

  // decimal adjust chain, lower nibble first so its carry reaches the upper
  always_comb begin
    lo_fix = (w_byte[3:0] > cfsd_pkg::BCD_LIMIT) || dc_in;
    sum1 = {1'b0, w_byte} + (lo_fix ? cfsd_pkg::BCD_FIX_LO : 9'h000);
    hi_fix = (sum1[7:4] > cfsd_pkg::BCD_LIMIT) || c_in || sum1[8];
    sum2 = sum1 + (hi_fix ? cfsd_pkg::BCD_FIX_HI : 9'h000);
  end

  // per-operation result and flags; carry and digit carry pass through, the other flags default to zero
  always_comb begin
    result = w_byte;
    c_out = c_in;
    dc_out = dc_in;
    n_out = 1'b0;
    ov_out = 1'b0;
    z_out = 1'b0;
    less = f_byte < w_byte; // unsigned compare
    unique case (op)
      cfsd_pkg::OP_DAW: begin
        result = sum2[7:0];
        c_out = c_in | sum1[8] | sum2[8];
      end
      cfsd_pkg::OP_DEC: begin
        result = f_byte - 8'h01;
        c_out = f_byte != 8'h00; // no borrow
        dc_out = f_byte[3:0] != 4'h0;
        n_out = result[7];
        ov_out = f_byte == cfsd_pkg::OV_EDGE;
        z_out = result == 8'h00;
      end
      cfsd_pkg::OP_CMP_LT, cfsd_pkg::OP_NONE: begin
        result = w_byte;
      end
    endcase
  end
endmodule // cfsd_alu

// File: cfsd_exec.sv
// execution of compare-skip-if-less, decimal adjust and decrement
// How it works
// RULE_01: compare-skip-if-less decoded from its seven-bit pattern
// RULE_02: unsigned compare; operands and flags stay untouched
// RULE_03: byte below W discards next fetched word
// RULE_04: bank bit picks access bank or bank register
// RULE_05: one cycle, two on skip, three over two-word
// RULE_06: decode, read, process, write; skip cycles idle
// RULE_07: decimal adjust corrects each nibble of W by six
// RULE_08: destination bit picks W or file register
// RULE_09: decrement updates carry, digit, negative, overflow, zero
module cfsd_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fetch side
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic next_two_word,
  output logic instr_cycle_start,
  output logic discard_fetched,
  output logic skip_pulse,
  output logic unknown_op,
  // banking
  input wire logic [3:0] bank_select_register,
  // data memory
  output logic [11:0] mem_addr,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // working register load by the rest of the core
  input wire logic wreg_load,
  input wire logic [7:0] wreg_load_data,
  // working register and status
  output logic [7:0] wreg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic negative_flag,
  output logic overflow_flag,
  output logic zero_flag
);
  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  // two-flop release so every flop leaves reset on the same edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // state
  cfsd_pkg::cfsd_phase_t phase, next_phase;
  cfsd_pkg::cfsd_op_t op, next_op;
  logic [7:0] fadr, next_fadr;
  logic dbit, next_dbit;
  logic [1:0] skip_left, next_skip_left;
  logic next_discard, next_skip_pulse, next_unknown;
  logic [11:0] next_mem_addr;
  logic next_mem_re, next_mem_we;
  logic [7:0] next_mem_wdata;
  logic [7:0] res, next_res;
  logic [4:0] rflags, next_rflags;
  logic [7:0] next_wreg;
  logic next_c, next_dc, next_n, next_ov, next_z;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_n, alu_ov, alu_z, alu_less;
  cfsd_pkg::cfsd_op_t dec_op;

  assign dec_op = cfsd_pkg::decode(instr_word);
  assign instr_cycle_start = phase == cfsd_pkg::PH_Q1;

  cfsd_alu u_alu (
    .op(op),
    .f_byte(mem_rdata),
    .w_byte(wreg),
    .c_in(carry_flag),
    .dc_in(digit_carry_flag),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .n_out(alu_n),
    .ov_out(alu_ov),
    .z_out(alu_z),
    .less(alu_less)
  );

  // ==========================================================
  // quadrature sequencing
  // memory read is issued in Q2, data sampled in Q3, written in Q4
  always_comb begin
    next_phase = phase;
    next_op = op;
    next_fadr = fadr;
    next_dbit = dbit;
    next_skip_left = skip_left;
    next_discard = discard_fetched;
    next_skip_pulse = 1'b0;
    next_unknown = unknown_op;
    next_mem_addr = mem_addr;
    next_mem_re = 1'b0;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_res = res;
    next_rflags = rflags;
    next_wreg = wreg;
    next_c = carry_flag;
    next_dc = digit_carry_flag;
    next_n = negative_flag;
    next_ov = overflow_flag;
    next_z = zero_flag;
    unique case (phase)
      cfsd_pkg::PH_Q1: begin
        next_phase = cfsd_pkg::PH_Q2;
        next_op = cfsd_pkg::OP_NONE;
        next_unknown = 1'b0;
        next_discard = 1'b0;
        if (skip_left != 2'h0) begin
          // fetched word thrown away; whole cycle is a no-op
          next_skip_left = skip_left - 2'h1; // RULE_05
          next_discard = 1'b1; // RULE_03
        end else if (instr_valid) begin
          next_op = dec_op; // RULE_01 RULE_07
          next_unknown = dec_op == cfsd_pkg::OP_NONE;
          next_fadr = instr_word[7:0];
          next_dbit = instr_word[cfsd_pkg::D_BIT];
          if (dec_op == cfsd_pkg::OP_CMP_LT ||
              dec_op == cfsd_pkg::OP_DEC) begin
            next_mem_re = 1'b1; // RULE_06
            next_mem_addr = cfsd_pkg::form_addr(instr_word[7:0],
              instr_word[cfsd_pkg::A_BIT], bank_select_register); // RULE_04
          end
        end
      end
      cfsd_pkg::PH_Q2: begin
        next_phase = cfsd_pkg::PH_Q3;
      end
      cfsd_pkg::PH_Q3: begin
        next_phase = cfsd_pkg::PH_Q4;
        next_res = alu_res;
        next_rflags = {alu_c, alu_dc, alu_n, alu_ov, alu_z};
        if (op == cfsd_pkg::OP_CMP_LT && alu_less) begin
          // two-word follower needs its second word dropped as well
          next_skip_left = next_two_word ? cfsd_pkg::SKIP_TWO
                                         : cfsd_pkg::SKIP_ONE; // RULE_03
          next_skip_pulse = 1'b1;
        end
        if (op == cfsd_pkg::OP_DEC && dbit) begin
          next_mem_we = 1'b1; // RULE_08
          next_mem_wdata = alu_res;
        end
      end
      cfsd_pkg::PH_Q4: begin
        next_phase = cfsd_pkg::PH_Q1;
        // the compare writes nothing here, so W stays free for loads
        if (wreg_load) next_wreg = wreg_load_data; // RULE_02
        if (op == cfsd_pkg::OP_DAW) begin
          next_wreg = res; // RULE_07
          next_c = rflags[4];
        end
        if (op == cfsd_pkg::OP_DEC) begin
          if (!dbit) next_wreg = res; // RULE_08
          {next_c, next_dc, next_n, next_ov, next_z} = rflags; // RULE_09
        end
      end
    endcase
  end

  // register every piece of sequencing state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= cfsd_pkg::PH_Q1;
      op <= cfsd_pkg::OP_NONE;
      fadr <= 8'h00;
      dbit <= 1'b0;
      skip_left <= 2'h0;
      discard_fetched <= 1'b0;
      skip_pulse <= 1'b0;
      unknown_op <= 1'b0;
      mem_addr <= 12'h000;
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      res <= 8'h00;
      rflags <= 5'h00;
      wreg <= 8'h00;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      negative_flag <= 1'b0;
      overflow_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else begin
      phase <= next_phase;
      op <= next_op;
      fadr <= next_fadr;
      dbit <= next_dbit;
      skip_left <= next_skip_left;
      discard_fetched <= next_discard;
      skip_pulse <= next_skip_pulse;
      unknown_op <= next_unknown;
      mem_addr <= next_mem_addr;
      mem_re <= next_mem_re;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      res <= next_res;
      rflags <= next_rflags;
      wreg <= next_wreg;
      carry_flag <= next_c;
      digit_carry_flag <= next_dc;
      negative_flag <= next_n;
      overflow_flag <= next_ov;
      zero_flag <= next_z;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = instr_cycle_start && instr_valid && skip_left == 2'h0;

  a_cmp_decode: assert property ( // RULE_01
    take && instr_word[15:9] == cfsd_pkg::CMP_LT_PATTERN
    |=> op == cfsd_pkg::OP_CMP_LT)
    else $error("compare word not decoded");
  // load is looked at on the Q4 edge, where it would land
  a_cmp_quiet: assert property ( // RULE_02
    take && dec_op == cfsd_pkg::OP_CMP_LT ##3 !wreg_load
    |=> $stable(wreg) && $stable(carry_flag) && $stable(zero_flag))
    else $error("compare changed W or flags");
  a_skip_discard: assert property ( // RULE_03
    skip_pulse |-> ##2 discard_fetched)
    else $error("fetched word not discarded after skip");
  a_bank_sel: assert property ( // RULE_04
    take && dec_op != cfsd_pkg::OP_NONE && dec_op != cfsd_pkg::OP_DAW &&
    instr_word[cfsd_pkg::A_BIT]
    |=> mem_re && mem_addr[11:8] == $past(bank_select_register))
    else $error("bank register not used for address");
  a_access_low: assert property ( // RULE_04
    mem_re && $past(instr_word[cfsd_pkg::A_BIT]) == 1'b0 &&
    mem_addr[7:0] < cfsd_pkg::ACCESS_SPLIT |-> mem_addr[11:8] == 4'h0)
    else $error("access bank low half misplaced");
  a_skip_two: assert property ( // RULE_05
    skip_pulse && skip_left == cfsd_pkg::SKIP_TWO
    |-> ##2 discard_fetched [*8] ##1 !discard_fetched)
    else $error("two-word skip length wrong");
  a_skip_one: assert property ( // RULE_05
    skip_pulse && skip_left == cfsd_pkg::SKIP_ONE
    |-> ##2 discard_fetched [*4] ##1 !discard_fetched)
    else $error("single skip length wrong");
  a_cmp_no_wr: assert property ( // RULE_06
    op == cfsd_pkg::OP_CMP_LT || discard_fetched |-> !mem_we)
    else $error("write during compare or skip");
  a_daw_low: assert property ( // RULE_07
    take && dec_op == cfsd_pkg::OP_DAW && wreg[3:0] > 4'h9
    |-> ##4 wreg[3:0] == $past(wreg[3:0], 4) + 4'h6)
    else $error("decimal adjust low nibble wrong");
  a_dec_file: assert property ( // RULE_08
    op == cfsd_pkg::OP_DEC && phase == cfsd_pkg::PH_Q3 && dbit
    |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01)
    else $error("decrement not written back");
  a_dec_zero: assert property ( // RULE_09
    op == cfsd_pkg::OP_DEC && phase == cfsd_pkg::PH_Q3 &&
    mem_rdata == 8'h01
    |-> ##2 zero_flag && carry_flag && !negative_flag)
    else $error("decrement flags wrong");

  c_skip_one: cover property (skip_pulse && skip_left == cfsd_pkg::SKIP_ONE);
  c_skip_two: cover property (skip_pulse && skip_left == cfsd_pkg::SKIP_TWO);
  c_daw: cover property (op == cfsd_pkg::OP_DAW && phase == cfsd_pkg::PH_Q4);
  c_dec_w: cover property (op == cfsd_pkg::OP_DEC && !dbit &&
    phase == cfsd_pkg::PH_Q4);
endmodule // cfsd_exec

// File: cfsd_mem_model.sv
// behavioural banked data memory facing the execution block
module cfsd_mem_model (
  // clock
  input wire logic sys_clk,
  // read and write port
  input wire logic [11:0] mem_addr,
  input wire logic mem_re,
  output logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  // ==========================================================
  // one clock read latency; the bus toggles when not read so that a
  // sample one clock late never sees the last good byte
  initial mem_rdata = 8'h00;
  always @(posedge sys_clk) begin
    if (mem_re) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule // cfsd_mem_model

// File: test_compare_skip_bcd_decrement_exec.sv
// self-checking bench for compare-skip, decimal adjust and decrement
module test_compare_skip_bcd_decrement_exec;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int due; logic [12:0] v;} cfsd_note_t;
  // ==========================================================
  // stimulus, outputs and expected state
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic next_two_word = 1'b0;
  logic [3:0] bank_select_register = 4'h0;
  logic wreg_load = 1'b0;
  logic [7:0] wreg_load_data = 8'h00;
  logic instr_cycle_start, discard_fetched, skip_pulse, unknown_op;
  logic mem_re, mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_rdata, mem_wdata, wreg;
  logic carry_flag, digit_carry_flag, negative_flag, overflow_flag;
  logic zero_flag;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int run_len = 0;
  int skip_left = 0;
  logic [7:0] ew = 8'h00;
  logic ec = 1'b0, edc = 1'b0, en = 1'b0, eov = 1'b0, ez = 1'b0;
  logic [7:0] edge_vals [4] = '{8'h00, 8'h80, 8'h10, 8'h01};
  logic [11:0] rq [$];
  logic [19:0] wq [$];
  int dq [$];
  cfsd_note_t sq [$];
  cfsd_note_t uq [$];
  logic [11:0] kq [$];
  cfsd_note_t s;

  cfsd_exec DUT (.sys_clk, .nrst, .instr_word, .instr_valid,
    .next_two_word, .instr_cycle_start, .discard_fetched, .skip_pulse,
    .unknown_op, .bank_select_register, .mem_addr, .mem_re, .mem_rdata,
    .mem_we, .mem_wdata, .wreg_load, .wreg_load_data, .wreg, .carry_flag,
    .digit_carry_flag, .negative_flag, .overflow_flag, .zero_flag);
  cfsd_mem_model mem_i (.sys_clk, .mem_addr, .mem_re, .mem_rdata,
    .mem_we, .mem_wdata);

  // ==========================================================
  // clock and edge counter
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ==========================================================
  // reporting and comparison
  task automatic bad(input logic [31:0] e, input logic [31:0] g);
    error_cnt++;
    $display("BAD %0t exp %h got %h", $time, e, g);
  endtask
  task automatic chk_mem(input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) bad({12'h000, e}, {12'h000, g});
  endtask
  task automatic chk_stat(input logic [12:0] e, input logic [12:0] g);
    tests_run++;
    if (g !== e) bad({19'h0, e}, {19'h0, g});
  endtask
  task automatic chk_run(input int e, input int g);
    tests_run++;
    if (g != e) bad(e, g);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // drivers; bounded wait for the first phase of a cycle
  task automatic wait_q1();
    int n;
    n = 0;
    @(negedge sys_clk);
    while (instr_cycle_start !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 8) begin
        error_cnt++;
        stop_test();
      end
    end
  endtask
  // load held a whole cycle, so its capture edge is always covered
  task automatic loadw(input logic [7:0] v);
    wait_q1();
    wreg_load = 1'b1;
    wreg_load_data = v;
    repeat (4) @(negedge sys_clk);
    wreg_load = 1'b0;
    ew = v;
  endtask
  // present one word and note every result it should cause
  task automatic run(input logic [15:0] wd, input logic two,
      input logic [7:0] fv);
    logic [11:0] ad;
    logic [8:0] t;
    logic [7:0] r;
    logic unk;
    unk = 1'b0;
    wait_q1();
    bank_select_register = 4'($urandom);
    if (wd[8]) ad = {bank_select_register, wd[7:0]};
    else ad = {(wd[7] ? 4'hf : 4'h0), wd[7:0]};
    mem_i.mem[ad] = fv;
    if (skip_left > 0) begin
      skip_left--;
    end else if (wd[15:9] == 7'h30) begin
      rq.push_back(ad);
      if (fv < ew) begin
        skip_left = two ? 2 : 1;
        kq.push_back(ad);
        dq.push_back(two ? 8 : 4);
      end
    end else if (wd[15:10] == 6'h01) begin
      rq.push_back(ad);
      r = fv - 8'h01;
      {ec, edc, en, eov, ez} = {fv != 8'h00, fv[3:0] != 4'h0, r[7],
        fv == 8'h80, r == 8'h00};
      if (wd[9]) wq.push_back({ad, r});
      else ew = r;
    end else if (wd == 16'h0007) begin
      t = {1'b0, ew} + ((ew[3:0] > 4'h9 || edc) ? 9'h006 : 9'h000);
      if (t[8:4] > 5'h09 || ec) t = t + 9'h060;
      ew = t[7:0];
      ec = ec | t[8];
    end else begin
      unk = 1'b1;
    end
    // unknown flag is looked at in Q2, right after the take
    uq.push_back('{cyc + 1, {12'h000, unk}});
    sq.push_back('{cyc + 6, {ew, ec, edc, en, eov, ez}});
    instr_word = wd;
    instr_valid = 1'b1;
    next_two_word = two;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask

  // ==========================================================
  // watcher: each result takes the oldest note of its kind
  always @(negedge sys_clk) begin
    if (mem_re === 1'b1) begin
      chk_mem({8'h00, rq.size() ? rq.pop_front() : 12'hxxx},
        {8'h00, mem_addr});
    end
    if (mem_we === 1'b1) begin
      chk_mem(wq.size() ? wq.pop_front() : 20'hxxxxx,
        {mem_addr, mem_wdata});
    end
    // skip pulse stands in Q4 while the compare address still holds
    if (skip_pulse === 1'b1) begin
      chk_mem({8'h00, kq.size() ? kq.pop_front() : 12'hxxx},
        {8'h00, mem_addr});
    end
    if (discard_fetched === 1'b1) begin
      run_len++;
    end else if (run_len > 0) begin
      chk_run(dq.size() ? dq.pop_front() : -1, run_len);
      run_len = 0;
    end
    if (uq.size() > 0 && uq[0].due == cyc) begin
      s = uq.pop_front();
      chk_stat(s.v, {12'h000, unknown_op});
    end
    if (sq.size() > 0 && sq[0].due == cyc) begin
      s = sq.pop_front();
      chk_stat(s.v, {wreg, carry_flag,
        digit_carry_flag, negative_flag, overflow_flag, zero_flag});
    end
  end

  // ==========================================================
  // main sequence: directed corners, then a random mix
  initial begin
    void'($urandom(91));
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    loadw(8'h50);
    run(16'h6010, 1'b0, 8'h50); // equal bytes never skip
    run(16'h6090, 1'b0, 8'h4f); // upper access half, skips
    run(16'h0623, 1'b0, 8'h77); // dropped behind the compare
    run(16'h6145, 1'b1, 8'h00); // bank register, two-word skip
    run(16'h0400, 1'b0, 8'h01);
    run(16'h0400, 1'b0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      run(16'h0620, 1'b0, edge_vals[i]);
      run(16'h0421, 1'b0, edge_vals[i]);
    end
    loadw(8'ha5);
    run(16'h0007, 1'b0, 8'h00);
    run(16'hffff, 1'b0, 8'h00); // unknown word has no effect
    for (int i = 0; i < 80; i++) begin
      case ($urandom_range(3))
        0: run({7'h30, 1'($urandom), 8'($urandom)}, 1'($urandom),
          8'($urandom));
        1: run({6'h01, 2'($urandom), 8'($urandom)}, 1'b0, 8'($urandom));
        2: run(16'h0007, 1'b0, 8'h00);
        default: if (skip_left == 0) loadw(8'($urandom));
      endcase
    end
    repeat (16) @(negedge sys_clk);
    if (rq.size() + wq.size() + dq.size() + sq.size() + uq.size() +
        kq.size() > 0) error_cnt++;
    stop_test();
  end

  // hang guard well beyond the run length of the sequence
  initial begin
    #40000;
    error_cnt++;
    stop_test();
  end
endmodule // test_compare_skip_bcd_decrement_exec
